// file: rtl/twsm_pkg.sv
// twsm_pkg: constants and types of the two-wire port (software master, hardware slave).
// assumes an 8-bit register port and a single 40 MHz core clock.
package twsm_pkg;

	// register offsets on the core register port
	localparam logic [7:0] OFF_CTL = 8'he8;
	localparam logic [7:0] OFF_BUF = 8'h9a;
	localparam logic [7:0] OFF_OWN = 8'h9b;
	localparam logic [7:0] OFF_SPCTL = 8'hc4;
	localparam logic [7:0] OFF_SECIE = 8'hc5;
	localparam logic [7:0] OFF_IE = 8'hc6;

	// reset values
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_BUF = 8'h00;
	localparam logic [7:0] RST_OWN = 8'h55;
	localparam logic [7:0] RST_SPCTL = 8'h00;
	localparam logic [7:0] RST_SECIE = 8'h00;
	localparam logic [7:0] RST_IE = 8'h00;

	// two_wire_control field positions
	localparam int CTL_MDO = 7;
	localparam int CTL_MDE = 6;
	localparam int CTL_MCO = 5;
	localparam int CTL_MDI = 4;
	localparam int CTL_MSEL = 3;
	localparam int CTL_IFRST = 2;
	localparam int CTL_DIR = 1;
	localparam int CTL_FLAG = 0;

	// other control bits
	localparam int SPCTL_SPE = 5;
	localparam int SECIE_TW = 0;
	localparam int IE_GLOBAL = 7;

	// interrupt vector of the byte-done event
	localparam logic [15:0] IRQ_VECTOR = 16'h003b;

	// spike filter timing
	localparam int GLITCH_NS = 50;
	localparam int MCLK_MHZ = 40;
	localparam int FILT_CYC = (GLITCH_NS * MCLK_MHZ + 999) / 1000;

	// slave controller states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_WAIT,
		ST_HALT
	} twsm_state_t;

endpackage

// file: rtl/twsm_port.sv
// twsm_port: two-wire serial port, software master mode and hardware slave mode.
// assumes pins are open-drain wires resolved outside; pin inputs are asynchronous to mclk.
//
// Behaviour
// - master select set means software master; clear means hardware slave.
// - with data drive enable set, data pin follows the data output value bit.
// - in master mode the clock pin is always driven from the clock output bit.
// - software clears data drive enable to receive; the data driver is released.
// - with driver off, data pin is caught into the input bit on clock rising edges.
// - after reset the port is a hardware slave, master select clear.
// - the port works only while the serial peripheral enable bit is clear.
// - slave matches own address and exchanges bytes through the byte buffer.
// - start, matching address and direction bit set the byte-done flag.
// - core interrupt needs port interrupt enable and global interrupt enable.
// - a byte buffer access clears byte-done flag and pending interrupt, except in a cycle where hardware sets the flag.
// - one buffer access per event; a second one halts the slave until reset bit.
// - the byte-done interrupt vectors to a fixed address after each byte.
// - the first byte in the buffer is the address plus direction bit.
// - direction flag holds the master's direction bit; software writes or reads.
// - after a valid address the clock pin is held low until the flag clears.
// - every byte followed by acknowledge sets the flag; none after not-acknowledge.
// - stop, or not-acknowledge at sequence end, returns the slave to idle.
// - interface reset bit forces the slave idle until software clears it.
// - both pin inputs are filtered against spikes shorter than the glitch width.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps

module twsm_port
	import twsm_pkg::*;
#(
	parameter int FILT_CYCLES = FILT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// serial data pin
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe_n,
	// serial clock pin
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n,
	// core interrupt
	output logic irq,
	output logic [15:0] irq_vector
);

	localparam int FW = $clog2(FILT_CYCLES + 1);

	// control bits
	logic sda_out_value_r;
	logic sda_drive_enable_r;
	logic scl_out_value_r;
	logic sda_in_sample_r;
	logic master_select_r;
	logic interface_reset_bit_r;
	logic direction_flag_r;
	logic byte_done_flag_r;
	logic [7:0] own_address_reg_r;
	logic [7:0] byte_buffer_reg_r;
	logic [7:0] serial_periph_control_r;
	logic [7:0] secondary_irq_enable_reg_r;
	logic [7:0] irq_enable_reg_r;
	logic used_r;

	// slave controller
	twsm_state_t state_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic seen_rise_r;
	logic sda_low_r;

	// outputs
	logic [7:0] rdata_r;
	logic sda_pin_r;
	logic sda_oe_n_r;
	logic scl_pin_r;
	logic scl_oe_n_r;
	logic irq_r;
	logic [15:0] irq_vector_r;

	// filtered pins and edges
	logic [1:0] pin_raw;
	logic [1:0] pin_filt;
	logic sda_f;
	logic scl_f;
	logic sda_prev_r;
	logic scl_prev_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	logic serial_periph_enable;
	logic master_en;
	logic slave_en;
	logic buf_acc;
	logic second_acc;
	logic ok_c;
	logic flag_set_c;
	logic load_buf_c;

	assign pin_raw = {serial_clock_pin_in, serial_data_pin_in};

	// two flops then a stability counter per line; a level is taken only after it held
	// for more than the glitch width, which costs that much latency on every edge
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			logic s1_r;
			logic s2_r;
			logic f_r;
			logic [FW-1:0] cnt_r;
			always_ff @(posedge mclk) begin
				if (rst) begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					f_r <= 1'b1;
					cnt_r <= '0;
				end else begin
					s1_r <= pin_raw[gi];
					s2_r <= s1_r;
					if (s2_r == f_r) begin
						cnt_r <= '0;
					end else if (cnt_r == FW'(FILT_CYCLES)) begin
						f_r <= s2_r;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + FW'(1);
					end
				end
			end
			assign pin_filt[gi] = f_r;
		end
	endgenerate

	assign sda_f = pin_filt[0];
	assign scl_f = pin_filt[1];

	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_prev_r <= 1'b1;
			scl_prev_r <= 1'b1;
		end else begin
			sda_prev_r <= sda_f;
			scl_prev_r <= scl_f;
		end
	end

	assign scl_rise = scl_f && !scl_prev_r;
	assign scl_fall = !scl_f && scl_prev_r;
	assign start_det = scl_f && scl_prev_r && !sda_f && sda_prev_r;
	assign stop_det = scl_f && scl_prev_r && sda_f && !sda_prev_r;

	assign serial_periph_enable = serial_periph_control_r[SPCTL_SPE];
	assign master_en = !serial_periph_enable && master_select_r;
	assign slave_en = !serial_periph_enable && !master_select_r;
	assign buf_acc = (reg_wr || reg_rd) && (reg_addr == OFF_BUF);
	assign second_acc = buf_acc && used_r && slave_en;
	assign ok_c = slave_en && !interface_reset_bit_r && !second_acc && !start_det && !stop_det;

	// a byte closes on the falling clock edge that ends its acknowledge bit
	always_comb begin
		flag_set_c = 1'b0;
		load_buf_c = 1'b0;
		if (ok_c && scl_fall && seen_rise_r) begin
			case (state_r)
				ST_ADDR_ACK, ST_RX_ACK: begin
					flag_set_c = 1'b1;
					load_buf_c = 1'b1;
				end
				ST_TX_ACK: begin
					flag_set_c = 1'b1;
				end
				default: begin
					flag_set_c = 1'b0;
				end
			endcase
		end
	end

	// software-written control bits
	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_out_value_r <= RST_CTL[CTL_MDO];
			sda_drive_enable_r <= RST_CTL[CTL_MDE];
			scl_out_value_r <= RST_CTL[CTL_MCO];
			master_select_r <= RST_CTL[CTL_MSEL];
			interface_reset_bit_r <= RST_CTL[CTL_IFRST];
			own_address_reg_r <= RST_OWN;
			serial_periph_control_r <= RST_SPCTL;
			secondary_irq_enable_reg_r <= RST_SECIE;
			irq_enable_reg_r <= RST_IE;
		end else if (reg_wr) begin
			case (reg_addr)
				OFF_CTL: begin
					sda_out_value_r <= reg_wdata[CTL_MDO];
					sda_drive_enable_r <= reg_wdata[CTL_MDE];
					scl_out_value_r <= reg_wdata[CTL_MCO];
					master_select_r <= reg_wdata[CTL_MSEL];
					interface_reset_bit_r <= reg_wdata[CTL_IFRST];
				end
				OFF_OWN: own_address_reg_r <= reg_wdata;
				OFF_SPCTL: serial_periph_control_r <= reg_wdata;
				OFF_SECIE: secondary_irq_enable_reg_r <= reg_wdata;
				OFF_IE: irq_enable_reg_r <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// master receive: pin level caught on each rising clock while the driver is off
	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_in_sample_r <= RST_CTL[CTL_MDI];
		end else if (master_en && !sda_drive_enable_r && scl_rise) begin
			sda_in_sample_r <= sda_f;
		end
	end

	// byte buffer, byte-done flag and access tracking; a hardware set beats a clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			byte_buffer_reg_r <= RST_BUF;
			byte_done_flag_r <= RST_CTL[CTL_FLAG];
			used_r <= 1'b0;
		end else begin
			if (load_buf_c) begin
				byte_buffer_reg_r <= shift_r;
			end else if (reg_wr && reg_addr == OFF_BUF) begin
				byte_buffer_reg_r <= reg_wdata;
			end
			if (flag_set_c) begin
				byte_done_flag_r <= 1'b1;
			end else if (buf_acc) begin
				byte_done_flag_r <= 1'b0;
			end
			if (flag_set_c || interface_reset_bit_r) begin
				used_r <= 1'b0;
			end else if (buf_acc) begin
				used_r <= 1'b1;
			end
		end
	end

	// hardware slave controller
	always_ff @(posedge mclk) begin
		if (rst || interface_reset_bit_r || !slave_en) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			seen_rise_r <= 1'b0;
			sda_low_r <= 1'b0;
			direction_flag_r <= RST_CTL[CTL_DIR];
		end else if (second_acc || state_r == ST_HALT) begin
			state_r <= ST_HALT;
			sda_low_r <= 1'b0;
		end else if (stop_det) begin
			state_r <= ST_IDLE;
			sda_low_r <= 1'b0;
		end else if (start_det) begin
			state_r <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_low_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					sda_low_r <= 1'b0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						seen_rise_r <= 1'b0;
						if (state_r == ST_RX) begin
							state_r <= ST_RX_ACK;
							sda_low_r <= 1'b1;
						end else if (shift_r[7:1] == own_address_reg_r[6:0]) begin
							state_r <= ST_ADDR_ACK;
							sda_low_r <= 1'b1;
							direction_flag_r <= shift_r[0];
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_rise) begin
						seen_rise_r <= 1'b1;
					end else if (scl_fall && seen_rise_r) begin
						sda_low_r <= 1'b0;
						state_r <= ST_WAIT;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_low_r <= 1'b0;
							seen_rise_r <= 1'b0;
							state_r <= ST_TX_ACK;
						end else begin
							sda_low_r <= !shift_r[6];
							shift_r <= {shift_r[6:0], 1'b0};
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						if (sda_f) begin
							state_r <= ST_IDLE;
						end else begin
							seen_rise_r <= 1'b1;
						end
					end else if (scl_fall && seen_rise_r) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// leave only once software has serviced the byte
					if (!byte_done_flag_r && !flag_set_c) begin
						bit_cnt_r <= 4'h0;
						if (direction_flag_r) begin
							state_r <= ST_TX;
							shift_r <= byte_buffer_reg_r;
							sda_low_r <= !byte_buffer_reg_r[7];
						end else begin
							state_r <= ST_RX;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// pin drivers; the slave only ever pulls low, the master drives both levels
	always_ff @(posedge mclk) begin
		if (rst || serial_periph_enable) begin
			sda_pin_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
			scl_pin_r <= 1'b1;
			scl_oe_n_r <= 1'b1;
		end else if (master_select_r) begin
			sda_pin_r <= sda_out_value_r;
			sda_oe_n_r <= !sda_drive_enable_r;
			scl_pin_r <= scl_out_value_r;
			scl_oe_n_r <= 1'b0;
		end else begin
			sda_pin_r <= !sda_low_r;
			sda_oe_n_r <= !sda_low_r;
			scl_pin_r <= state_r != ST_WAIT;
			scl_oe_n_r <= state_r != ST_WAIT;
		end
	end

	// core interrupt request and its vector
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_r <= 1'b0;
			irq_vector_r <= 16'h0000;
		end else begin
			irq_r <= byte_done_flag_r && secondary_irq_enable_reg_r[SECIE_TW] &&
				irq_enable_reg_r[IE_GLOBAL];
			irq_vector_r <= (byte_done_flag_r && secondary_irq_enable_reg_r[SECIE_TW] &&
				irq_enable_reg_r[IE_GLOBAL]) ? IRQ_VECTOR : 16'h0000;
		end
	end

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (rst || !reg_rd) begin
			rdata_r <= 8'h00;
		end else begin
			case (reg_addr)
				OFF_CTL: rdata_r <= {sda_out_value_r, sda_drive_enable_r, scl_out_value_r, sda_in_sample_r,
					master_select_r, interface_reset_bit_r, direction_flag_r, byte_done_flag_r};
				OFF_OWN: rdata_r <= own_address_reg_r;
				OFF_BUF: rdata_r <= byte_buffer_reg_r;
				OFF_SPCTL: rdata_r <= serial_periph_control_r;
				OFF_SECIE: rdata_r <= secondary_irq_enable_reg_r;
				OFF_IE: rdata_r <= irq_enable_reg_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_r;
	assign serial_data_pin_out = sda_pin_r;
	assign serial_data_pin_oe_n = sda_oe_n_r;
	assign serial_clock_pin_out = scl_pin_r;
	assign serial_clock_pin_oe_n = scl_oe_n_r;
	assign irq = irq_r;
	assign irq_vector = irq_vector_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	slave_after_reset_a: assert property (
		$fell(rst) |-> !master_select_r && state_r == ST_IDLE)
		else $error("port not in slave mode after reset");

	sda_drive_a: assert property (
		master_en && sda_drive_enable_r |=> !serial_data_pin_oe_n && serial_data_pin_out == $past(sda_out_value_r))
		else $error("data pin does not follow data output bit");

	scl_master_a: assert property (
		master_en |=> !serial_clock_pin_oe_n && serial_clock_pin_out == $past(scl_out_value_r))
		else $error("clock pin not driven in master mode");

	sda_release_a: assert property (
		master_en && !sda_drive_enable_r |=> serial_data_pin_oe_n)
		else $error("data driver not released for receive");

	mdi_capture_a: assert property (
		master_en && !sda_drive_enable_r && scl_rise |=> sda_in_sample_r == $past(sda_f))
		else $error("data input bit not caught on clock rise");

	pins_off_a: assert property (
		serial_periph_enable |=> serial_data_pin_oe_n && serial_clock_pin_oe_n)
		else $error("pins driven while serial peripheral enabled");

	buf_clear_a: assert property (
		buf_acc && !flag_set_c |=> !byte_done_flag_r ##1 !irq_r)
		else $error("buffer access did not clear flag and interrupt");

	access_halt_a: assert property (
		second_acc && !interface_reset_bit_r |=> state_r == ST_HALT)
		else $error("second buffer access did not halt slave");

	scl_stretch_a: assert property (
		slave_en && state_r == ST_WAIT |=> !serial_clock_pin_oe_n && !serial_clock_pin_out)
		else $error("clock not held low while byte pending");

	irq_vector_a: assert property (
		irq_r |-> irq_vector == IRQ_VECTOR && $past(byte_done_flag_r))
		else $error("interrupt without vector or flag");

	ifreset_idle_a: assert property (
		slave_en && interface_reset_bit_r |=> state_r == ST_IDLE ##1 serial_data_pin_oe_n && serial_clock_pin_oe_n)
		else $error("interface reset did not idle the slave");

	nack_idle_a: assert property (
		ok_c && state_r == ST_TX_ACK && scl_rise && sda_f |=> state_r == ST_IDLE && !$rose(byte_done_flag_r))
		else $error("not-acknowledge did not return slave to idle");

	addr_ack_a: assert property (
		ok_c && state_r == ST_ADDR && scl_fall && bit_cnt_r == 4'h8 && shift_r[7:1] == own_address_reg_r[6:0]
		|=> state_r == ST_ADDR_ACK ##1 !serial_data_pin_oe_n)
		else $error("matching address not acknowledged");

endmodule // twsm_port

// file: verif/twsm_wire_master.sv
// twsm_wire_master: behavioural two-wire bus master standing on the wire side of the port.
// assumes open-drain wires with pull-ups resolved by the bench; 300 ns bit period from delays.
// the low phase is long enough for the slave to answer through its pin filter before the clock rises.
`timescale 1ns/1ps

module twsm_wire_master (
	// resolved wire levels
	input wire logic sda,
	input wire logic scl,
	// pull-down requests
	output logic sda_low,
	output logic scl_low
);
	int n_stall;

	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
		n_stall = 0;
	end

	// a slave may stretch the clock, so wait for the wire, but never forever
	task automatic clk_high();
		int k;
		k = 0;
		scl_low = 1'b0;
		while (scl !== 1'b1 && k < 2000) begin
			#25;
			k++;
		end
		if (scl !== 1'b1) n_stall++;
	endtask

	// data moves mid-low; sampled late in the high phase since the slave answers through its filter
	task automatic put_bit(input logic b, output logic seen);
		#100 sda_low = ~b;
		#100 clk_high();
		#95 seen = sda;
		#5 scl_low = 1'b1;
	endtask

	task automatic start();
		sda_low = 1'b1;
		#100 scl_low = 1'b1;
	endtask

	task automatic stop();
		#100 sda_low = 1'b1;
		#100 clk_high();
		#100 sda_low = 1'b0;
		#100;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) put_bit(b[i], s);
		put_bit(1'b1, ack);
	endtask

	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			b[i] = s;
		end
		put_bit(nack, s);
	endtask
endmodule // twsm_wire_master

// file: verif/twsm_port_tb.sv
// twsm_port_tb: self-checking bench of the two-wire port in both modes.
// assumes the wire master model beside it and open-drain wires with pull-ups.
`timescale 1ns/1ps

module twsm_port_tb;
	import twsm_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic sda_out, sda_oe_n, scl_out, scl_oe_n, irq;
	logic [15:0] irq_vector;
	logic sda_w, scl_w, m_sda_low, m_scl_low;
	logic [7:0] lfsr_r = 8'h47;
	logic [7:0] v, c, d, own;
	logic ack;
	int n_mismatch = 0;
	int num_checks = 0;

	always #12.5 mclk = ~mclk;
	assign sda_w = !(m_sda_low || (!sda_oe_n && !sda_out));
	assign scl_w = !(m_scl_low || (!scl_oe_n && !scl_out));

	twsm_port #(.FILT_CYCLES(1)) dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_data_pin_in(sda_w),
		.serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n), .serial_clock_pin_in(scl_w),
		.serial_clock_pin_out(scl_out), .serial_clock_pin_oe_n(scl_oe_n), .irq(irq), .irq_vector(irq_vector));
	twsm_wire_master m (.sda(sda_w), .scl(scl_w), .sda_low(m_sda_low), .scl_low(m_scl_low));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] addr_byte(input logic [7:0] a, input logic dir);
		return {a[6:0], dir};
	endfunction

	task automatic rnd(output logic [7:0] r);
		lfsr_r = lfsr_next(lfsr_r);
		r = lfsr_r;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 dat = reg_rdata;
	endtask

	task automatic addr_phase(input logic [7:0] ab, input logic exp_ack);
		m.start();
		m.send_byte(ab, ack);
		chk_bit(ack, exp_ack);
	endtask

	// polls the flag the way software without interrupts would
	task automatic wait_flag(input logic exp_irq, output logic [7:0] ctl);
		int k;
		k = 0;
		ctl = 8'h00;
		while (ctl[CTL_FLAG] !== 1'b1 && k < 40) begin
			rd(OFF_CTL, ctl);
			k++;
		end
		chk_bit(ctl[CTL_FLAG], 1'b1);
		chk_bit(irq, exp_irq);
		chk_val(irq_vector, exp_irq ? IRQ_VECTOR : 16'h0000);
		chk_val({14'h0000, scl_oe_n, scl_out}, 16'h0000);
	endtask

	task automatic after_access();
		logic [7:0] ctl;
		cyc(4);
		rd(OFF_CTL, ctl);
		chk_bit(ctl[CTL_FLAG], 1'b0);
		chk_bit(irq, 1'b0);
		chk_bit(scl_oe_n, 1'b1);
	endtask

	task automatic give_verdict();
		n_mismatch += m.n_stall;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		#500000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		logic [7:0] offs [6];
		logic [7:0] vals [6];
		offs = '{OFF_CTL, OFF_OWN, OFF_BUF, OFF_SPCTL, OFF_SECIE, OFF_IE};
		vals = '{RST_CTL, RST_OWN, RST_BUF, RST_SPCTL, RST_SECIE, RST_IE};
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (int j = 0; j < 6; j++) begin
			rd(offs[j], d);
			chk_val({8'h00, d}, {8'h00, vals[j]});
		end
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		chk_val({8'h00, d}, 16'h0000);
		wr(OFF_CTL, 8'h13);
		rd(OFF_CTL, d);
		chk_val({8'h00, d}, 16'h0000);
		chk_val({14'h0000, sda_oe_n, scl_oe_n}, 16'h0003);
		$display("test reset done");
		for (int j = 0; j < 6; j++) begin
			rnd(v);
			wr(OFF_CTL, {v[7], j[0], v[5], 5'b01000});
			cyc(2);
			chk_bit(sda_oe_n, ~j[0]);
			if (j[0]) chk_bit(sda_out, v[7]);
			chk_val({14'h0000, scl_oe_n, scl_out}, {15'h0000, v[5]});
		end
		for (int j = 0; j < 4; j++) begin
			rnd(v);
			wr(OFF_CTL, 8'h08);
			m.sda_low = v[0];
			cyc(8);
			wr(OFF_CTL, 8'h28);
			cyc(10);
			m.sda_low = ~v[0];
			cyc(10);
			rd(OFF_CTL, c);
			chk_bit(c[CTL_MDI], ~v[0]);
		end
		m.sda_low = 1'b0;
		wr(OFF_CTL, 8'h68);
		wr(OFF_SPCTL, 8'h20);
		cyc(2);
		chk_val({14'h0000, sda_oe_n, scl_oe_n}, 16'h0003);
		wr(OFF_SPCTL, 8'h00);
		wr(OFF_CTL, 8'h00);
		wr(OFF_CTL, 8'h04);
		wr(OFF_CTL, 8'h00);
		$display("test master done");
		rnd(v);
		own = v & 8'h7f;
		wr(OFF_OWN, own);
		wr(OFF_SECIE, 8'h01);
		wr(OFF_IE, 8'h80);
		addr_phase(addr_byte(own, 1'b0), 1'b0);
		wait_flag(1'b1, c);
		chk_bit(c[CTL_DIR], 1'b0);
		rd(OFF_BUF, d);
		chk_val({8'h00, d}, {8'h00, addr_byte(own, 1'b0)});
		after_access();
		for (int j = 0; j < 3; j++) begin
			rnd(v);
			m.send_byte(v, ack);
			chk_bit(ack, 1'b0);
			wait_flag(1'b1, c);
			rd(OFF_BUF, d);
			chk_val({8'h00, d}, {8'h00, v});
			after_access();
		end
		m.stop();
		$display("test slave receive done");
		addr_phase(addr_byte(own, 1'b1), 1'b0);
		wait_flag(1'b1, c);
		chk_bit(c[CTL_DIR], 1'b1);
		for (int j = 0; j < 2; j++) begin
			rnd(v);
			wr(OFF_BUF, v);
			after_access();
			m.recv_byte(j[0], d);
			chk_val({8'h00, d}, {8'h00, v});
			if (j == 0) wait_flag(1'b1, c);
		end
		cyc(20);
		rd(OFF_CTL, c);
		chk_bit(c[CTL_FLAG], 1'b0);
		chk_bit(scl_oe_n, 1'b1);
		m.stop();
		$display("test slave transmit done");
		addr_phase(addr_byte(own ^ 8'h01, 1'b0), 1'b1);
		cyc(20);
		rd(OFF_CTL, c);
		chk_bit(c[CTL_FLAG], 1'b0);
		m.stop();
		$display("test foreign address done");
		wr(OFF_SECIE, 8'h00);
		addr_phase(addr_byte(own, 1'b0), 1'b0);
		wait_flag(1'b0, c);
		rd(OFF_BUF, d);
		rd(OFF_BUF, d);
		cyc(4);
		chk_val({14'h0000, sda_oe_n, scl_oe_n}, 16'h0003);
		m.stop();
		addr_phase(addr_byte(own, 1'b0), 1'b1);
		m.stop();
		wr(OFF_CTL, 8'h04);
		addr_phase(addr_byte(own, 1'b0), 1'b1);
		m.stop();
		wr(OFF_CTL, 8'h00);
		addr_phase(addr_byte(own, 1'b0), 1'b0);
		wait_flag(1'b0, c);
		rd(OFF_BUF, d);
		chk_val({8'h00, d}, {8'h00, addr_byte(own, 1'b0)});
		after_access();
		m.stop();
		$display("test halt and interface reset done");
		give_verdict();
	end
endmodule // twsm_port_tb
